/* hw/aje_exec.sv */
// Execution datapath: byte and word ALU, multiplier and program counter updates.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "aje_regs.svh"
module aje_exec
  import aje_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // APB answer.
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ==========================================
  // Functions.
  function automatic logic [10:0] aje_add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    aje_add8 = {(a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]),
                (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]), s[8], s[7:0]};
  endfunction

  function automatic logic [10:0] aje_sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    aje_sub8 = {(~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]),
                (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]), s[8], s[7:0]};
  endfunction

  // Sets Z, N and V from a byte result; other flags are kept.
  function automatic logic [7:0] aje_znv(input logic [7:0] fl, input logic [7:0] r, input logic v);
    logic [7:0] f;
    f = fl;
    f[`AJE_FL_Z] = (r == 8'h00);
    f[`AJE_FL_N] = r[7];
    f[`AJE_FL_V] = v;
    aje_znv = f;
  endfunction

  // Sets Z, C, N, V and H from an arithmetic result word {h, v, c, r}.
  function automatic logic [7:0] aje_zcnvh(input logic [7:0] fl, input logic [10:0] hvcr);
    logic [7:0] f;
    f = aje_znv(fl, hvcr[7:0], hvcr[9]);
    f[`AJE_FL_C] = hvcr[8];
    f[`AJE_FL_H] = hvcr[10];
    aje_zcnvh = f;
  endfunction

  function automatic logic [2:0] aje_cycles(input aje_op_t o);
    logic [2:0] c;
    c = `AJE_CYC_ALU;
    unique case (o)
      AJE_WORD_ADD, AJE_WORD_MINUS: c = `AJE_CYC_WORD;
      AJE_UPROD, AJE_SPROD, AJE_MPROD, AJE_FUPROD, AJE_FSPROD, AJE_FMPROD: c = `AJE_CYC_MUL;
      AJE_REL_JUMP:   c = `AJE_CYC_RELATIVE_JUMP_OP;
      AJE_IND_JUMP:   c = `AJE_CYC_INDIRECT_JUMP_OP;
      AJE_ABS_JUMP:   c = `AJE_CYC_JMP;
      AJE_REL_INVOKE: c = `AJE_CYC_RELATIVE_SUBROUTINE_INVOKE;
      AJE_IND_INVOKE: c = `AJE_CYC_INDIRECT_SUBROUTINE_INVOKE;
      AJE_ABS_INVOKE: c = `AJE_CYC_CALL;
      AJE_SUB_EXIT:   c = `AJE_CYC_RET;
      default:        c = `AJE_CYC_ALU;
    endcase
    aje_cycles = c;
  endfunction

  // ==========================================
  // State.
  aje_state_t  state;
  aje_op_t     op;
  logic [2:0]  cnt;
  logic [7:0]  opa;
  logic [7:0]  opb;
  logic [15:0] word;
  logic [15:0] ptr;
  logic [15:0] tgt;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic [7:0]  res;
  logic [15:0] prod;
  logic [15:0] stk [0:7];
  logic [2:0]  sp;
  logic [3:0]  depth;

  logic        setup;
  logic        wok;
  logic        busy;
  logic        commit;
  logic        legal;
  logic        mapped;
  logic        rdonly;
  logic [31:0] rdata;

  logic [7:0]  next_res;
  logic [7:0]  next_flags;
  logic [15:0] next_word;
  logic [15:0] next_prod;
  logic [15:0] next_pc;
  logic        push;
  logic        pop;
  logic [15:0] ret_addr;
  logic [10:0] ar;
  logic [10:0] sr;
  logic [7:0]  ab;
  logic        ac;
  logic [7:0]  sa;
  logic [7:0]  sb;
  logic        sc;
  logic [16:0] wsum;
  logic signed [8:0]  ma;
  logic signed [8:0]  mb;
  logic signed [17:0] mfull;
  logic [15:0] mp;

  assign busy   = (state == AJE_EXEC);
  assign commit = busy && (cnt == 3'h1);
  assign setup  = psel && penable && !pready;
  assign wok    = psel && penable && pready && pwrite && !pslverr;

  // ==========================================
  // APB decode and answer.
  always_comb begin
    legal  = (pwdata[5:0] <= AJE_SUB_EXIT);
    mapped = 1'b1;
    rdonly = 1'b0;
    rdata  = 32'h0000_0000;
    unique case (paddr)
      `AJE_OFF_CMD:   rdata = {26'h000_0000, op};
      `AJE_OFF_OPA:   rdata = {24'h00_0000, opa};
      `AJE_OFF_OPB:   rdata = {24'h00_0000, opb};
      `AJE_OFF_WORD:  rdata = {16'h0000, word};
      `AJE_OFF_PTR:   rdata = {16'h0000, ptr};
      `AJE_OFF_TGT:   rdata = {16'h0000, tgt};
      `AJE_OFF_PC:    rdata = {16'h0000, pc};
      `AJE_OFF_FLAGS: rdata = {24'h00_0000, flags};
      `AJE_OFF_RES: begin
        rdata  = {24'h00_0000, res};
        rdonly = 1'b1;
      end
      `AJE_OFF_PROD: begin
        rdata  = {16'h0000, prod};
        rdonly = 1'b1;
      end
      `AJE_OFF_STAT: begin
        rdata  = {24'h00_0000, depth, cnt, busy};
        rdonly = 1'b1;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && (!mapped || (pwrite && (busy || rdonly ||
                 (paddr == `AJE_OFF_CMD && !legal))));
      prdata  <= (setup && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ==========================================
  // Sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= AJE_IDLE;
      cnt   <= 3'h0;
      op    <= AJE_ADD_REGS;
    end else begin
      unique case (state)
        AJE_IDLE: begin
          if (wok && paddr == `AJE_OFF_CMD) begin
            op    <= aje_op_t'(pwdata[5:0]);
            cnt   <= aje_cycles(aje_op_t'(pwdata[5:0]));
            state <= AJE_EXEC;
          end
        end
        AJE_EXEC: begin
          cnt <= cnt - 3'h1;
          if (commit) begin
            state <= AJE_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Datapath.
  always_comb begin
    ab = (op == AJE_PLUS_ONE) ? 8'h01 : opb;
    ac = (op == AJE_ADD_CARRY) && flags[`AJE_FL_C];
    sa = (op == AJE_SIGN_FLIP) ? 8'h00 : opa;
    sb = (op == AJE_SIGN_FLIP) ? opa : ((op == AJE_MINUS_ONE) ? 8'h01 : opb);
    sc = (op == AJE_BORROW_REG || op == AJE_BORROW_IMM) && flags[`AJE_FL_C];
    ar = aje_add8(opa, ab, ac);
    sr = aje_sub8(sa, sb, sc);
    ma = (op == AJE_SPROD || op == AJE_MPROD || op == AJE_FSPROD || op == AJE_FMPROD) ?
         {opa[7], opa} : {1'b0, opa};
    mb = (op == AJE_SPROD || op == AJE_FSPROD) ? {opb[7], opb} : {1'b0, opb};
    mfull = ma * mb;
    mp = mfull[15:0];
    wsum = (op == AJE_WORD_MINUS) ? ({1'b0, word} - {9'h000, opb}) : ({1'b0, word} + {9'h000, opb});
    next_res   = opa;
    next_flags = flags;
    next_word  = word;
    next_prod  = prod;
    next_pc    = pc;
    push       = 1'b0;
    pop        = 1'b0;
    ret_addr   = pc + 16'h0001;
    unique case (op)
      AJE_ADD_REGS, AJE_ADD_CARRY, AJE_PLUS_ONE: begin
        next_res   = ar[7:0];
        next_flags = (op == AJE_PLUS_ONE) ? aje_znv(flags, ar[7:0], ar[9]) : aje_zcnvh(flags, ar);
      end
      AJE_MINUS_REGS, AJE_MINUS_IMM, AJE_BORROW_REG, AJE_BORROW_IMM, AJE_SIGN_FLIP, AJE_MINUS_ONE: begin
        next_res   = sr[7:0];
        next_flags = aje_zcnvh(flags, sr);
        if (sc || op == AJE_BORROW_REG || op == AJE_BORROW_IMM) begin
          next_flags[`AJE_FL_Z] = (sr[7:0] == 8'h00) && flags[`AJE_FL_Z];
        end
        if (op == AJE_SIGN_FLIP) begin
          next_flags[`AJE_FL_H] = sr[3] | opa[3];
        end
        if (op == AJE_MINUS_ONE) begin
          next_flags = aje_znv(flags, sr[7:0], sr[9]);
        end
      end
      AJE_WORD_ADD, AJE_WORD_MINUS: begin
        next_word = wsum[15:0];
        next_flags[`AJE_FL_Z] = (wsum[15:0] == 16'h0000);
        next_flags[`AJE_FL_N] = wsum[15];
        next_flags[`AJE_FL_C] = wsum[16];
        next_flags[`AJE_FL_V] = (op == AJE_WORD_MINUS) ? (word[15] & ~wsum[15]) : (~word[15] & wsum[15]);
        next_flags[`AJE_FL_S] = wsum[15] ^ next_flags[`AJE_FL_V];
      end
      AJE_CONJ_REGS, AJE_CONJ_IMM: begin
        next_res   = opa & opb;
        next_flags = aje_znv(flags, opa & opb, 1'b0);
      end
      AJE_DISJ_REGS, AJE_DISJ_IMM, AJE_SET_BITS: begin
        next_res   = opa | opb;
        next_flags = aje_znv(flags, opa | opb, 1'b0);
      end
      AJE_XOR_REGS: begin
        next_res   = opa ^ opb;
        next_flags = aje_znv(flags, opa ^ opb, 1'b0);
      end
      AJE_INVERT: begin
        next_res   = 8'hff - opa;
        next_flags = aje_znv(flags, 8'hff - opa, 1'b0);
        next_flags[`AJE_FL_C] = 1'b1;
      end
      AJE_CLEAR_BITS: begin
        next_res   = opa & (8'hff - opb);
        next_flags = aje_znv(flags, opa & (8'hff - opb), 1'b0);
      end
      AJE_ZS_TEST: begin
        next_res   = opa & opa;
        next_flags = aje_znv(flags, opa & opa, 1'b0);
      end
      AJE_ZERO_REG: begin
        next_res   = opa ^ opa;
        next_flags = aje_znv(flags, opa ^ opa, 1'b0);
      end
      AJE_FILL_ONES: begin
        next_res = 8'hff;
      end
      AJE_UPROD, AJE_SPROD, AJE_MPROD: begin
        next_prod = mp;
        next_flags[`AJE_FL_C] = mp[15];
        next_flags[`AJE_FL_Z] = (mp == 16'h0000);
      end
      AJE_FUPROD, AJE_FSPROD, AJE_FMPROD: begin
        next_prod = {mp[14:0], 1'b0};
        next_flags[`AJE_FL_C] = mp[15];
        next_flags[`AJE_FL_Z] = (mp[14:0] == 15'h0000);
      end
      AJE_REL_JUMP: begin
        next_pc = pc + tgt + 16'h0001;
      end
      AJE_IND_JUMP: begin
        next_pc = ptr;
      end
      AJE_ABS_JUMP: begin
        next_pc = tgt;
      end
      AJE_REL_INVOKE: begin
        next_pc = pc + tgt + 16'h0001;
        push    = 1'b1;
      end
      AJE_IND_INVOKE: begin
        next_pc = ptr;
        push    = 1'b1;
      end
      AJE_ABS_INVOKE: begin
        next_pc  = tgt;
        push     = 1'b1;
        ret_addr = pc + 16'h0002;
      end
      AJE_SUB_EXIT: begin
        next_pc = stk[sp - 3'h1];
        pop     = 1'b1;
      end
    endcase
  end

  // ==========================================
  // Operand and pointer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa <= `AJE_RST_BYTE;
      opb <= `AJE_RST_BYTE;
      ptr <= `AJE_RST_WORD;
      tgt <= `AJE_RST_WORD;
    end else begin
      if (commit) begin
        opa <= next_res;
      end else if (wok && paddr == `AJE_OFF_OPA) begin
        opa <= pwdata[7:0];
      end
      if (wok && paddr == `AJE_OFF_OPB) begin
        opb <= pwdata[7:0];
      end
      if (wok && paddr == `AJE_OFF_PTR) begin
        ptr <= pwdata[15:0];
      end
      if (wok && paddr == `AJE_OFF_TGT) begin
        tgt <= pwdata[15:0];
      end
    end
  end

  // ==========================================
  // Results and flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res   <= `AJE_RST_BYTE;
      prod  <= `AJE_RST_WORD;
      word  <= `AJE_RST_WORD;
      flags <= `AJE_RST_FLAGS;
    end else if (commit) begin
      res   <= next_res;
      prod  <= next_prod;
      word  <= next_word;
      flags <= next_flags;
    end else begin
      if (wok && paddr == `AJE_OFF_WORD) begin
        word <= pwdata[15:0];
      end
      if (wok && paddr == `AJE_OFF_FLAGS) begin
        flags <= pwdata[7:0];
      end
    end
  end

  // ==========================================
  // Program counter and return stack.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc    <= `AJE_RST_WORD;
      sp    <= 3'h0;
      depth <= 4'h0;
    end else if (commit) begin
      pc <= next_pc;
      if (push) begin
        sp    <= sp + 3'h1;
        depth <= (depth == 4'h8) ? depth : depth + 4'h1;
      end else if (pop) begin
        sp    <= sp - 3'h1;
        depth <= (depth == 4'h0) ? depth : depth - 4'h1;
      end
    end else if (wok && paddr == `AJE_OFF_PC) begin
      pc <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (commit && push) begin
      stk[sp] <= ret_addr;
    end
  end

endmodule

/* hw/aje_regs.svh */
// Register offsets, field positions, reset values and cycle counts.
`ifndef AJE_REGS_SVH
`define AJE_REGS_SVH
// ==========================================
// Register byte offsets.
`define AJE_OFF_CMD   8'h00
`define AJE_OFF_OPA   8'h04
`define AJE_OFF_OPB   8'h08
`define AJE_OFF_WORD  8'h0c
`define AJE_OFF_PTR   8'h10
`define AJE_OFF_TGT   8'h14
`define AJE_OFF_PC    8'h18
`define AJE_OFF_FLAGS 8'h1c
`define AJE_OFF_RES   8'h20
`define AJE_OFF_PROD  8'h24
`define AJE_OFF_STAT  8'h28
// ==========================================
// Flag bit positions.
`define AJE_FL_C 0
`define AJE_FL_Z 1
`define AJE_FL_N 2
`define AJE_FL_V 3
`define AJE_FL_S 4
`define AJE_FL_H 5
// ==========================================
// Reset values.
`define AJE_RST_BYTE  8'h00
`define AJE_RST_WORD  16'h0000
`define AJE_RST_FLAGS 8'h00
// ==========================================
// Execution cycle counts.
`define AJE_CYC_ALU   3'h1
`define AJE_CYC_WORD  3'h2
`define AJE_CYC_MUL   3'h2
`define AJE_CYC_RELATIVE_JUMP_OP  3'h2
`define AJE_CYC_INDIRECT_JUMP_OP  3'h2
`define AJE_CYC_JMP   3'h3
`define AJE_CYC_RELATIVE_SUBROUTINE_INVOKE 3'h4
`define AJE_CYC_INDIRECT_SUBROUTINE_INVOKE 3'h4
`define AJE_CYC_CALL  3'h5
`define AJE_CYC_RET   3'h5
`endif

/* hw/aje_pkg.sv */
// Types shared by the execution datapath.
package aje_pkg;
  typedef enum logic [5:0] {
    AJE_ADD_REGS   = 6'h00, AJE_ADD_CARRY  = 6'h01, AJE_WORD_ADD   = 6'h02,
    AJE_MINUS_REGS = 6'h03, AJE_MINUS_IMM  = 6'h04, AJE_BORROW_REG = 6'h05,
    AJE_BORROW_IMM = 6'h06, AJE_WORD_MINUS = 6'h07, AJE_CONJ_REGS  = 6'h08,
    AJE_CONJ_IMM   = 6'h09, AJE_DISJ_REGS  = 6'h0a, AJE_DISJ_IMM   = 6'h0b,
    AJE_XOR_REGS   = 6'h0c, AJE_INVERT     = 6'h0d, AJE_SIGN_FLIP  = 6'h0e,
    AJE_SET_BITS   = 6'h0f, AJE_CLEAR_BITS = 6'h10, AJE_PLUS_ONE   = 6'h11,
    AJE_MINUS_ONE  = 6'h12, AJE_ZS_TEST    = 6'h13, AJE_ZERO_REG   = 6'h14,
    AJE_FILL_ONES  = 6'h15, AJE_UPROD      = 6'h16, AJE_SPROD      = 6'h17,
    AJE_MPROD      = 6'h18, AJE_FUPROD     = 6'h19, AJE_FSPROD     = 6'h1a,
    AJE_FMPROD     = 6'h1b, AJE_REL_JUMP   = 6'h1c, AJE_IND_JUMP   = 6'h1d,
    AJE_ABS_JUMP   = 6'h1e, AJE_REL_INVOKE = 6'h1f, AJE_IND_INVOKE = 6'h20,
    AJE_ABS_INVOKE = 6'h21, AJE_SUB_EXIT   = 6'h22
  } aje_op_t;
  typedef enum logic [1:0] {
    AJE_IDLE = 2'b01,
    AJE_EXEC = 2'b10
  } aje_state_t;
endpackage

/* testbench/aje_exec_checker.sv */
// Concurrent checks on the APB ports of the execution datapath.
`timescale 1ns/1ps
module aje_exec_checker (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB request.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // APB answer.
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [2:0] left;
  logic       pen_q;
  wire        map = paddr[1:0] == 2'h0 && paddr <= 8'h28;
  wire        acc = penable && !pen_q && psel;
  wire        cmd = psel && penable && pready && pwrite && !pslverr && paddr == 8'h00;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Cycles left of the running operation.
  function automatic logic [2:0] n_of(input logic [5:0] op);
    if (op == 6'h02 || op == 6'h07 || (op >= 6'h16 && op <= 6'h1d)) return 3'h2;
    if (op == 6'h1e) return 3'h3;
    if (op == 6'h1f || op == 6'h20) return 3'h4;
    if (op >= 6'h21) return 3'h5;
    return 3'h1;
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 3'h0;
    end else if (cmd) begin
      left <= n_of(pwdata[5:0]);
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end
  // Previous penable, so that acc marks the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_q <= 1'b0;
    end else begin
      pen_q <= penable;
    end
  end
  // ==========================================
  // Assertions.
  property p_one_wait; acc |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_idle; !(psel && penable) |=> !pready && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("answer without access");
  property p_rdata; !pready |-> prdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("prdata not zero outside answer");
  property p_unmapped; acc && !map |=> pready && pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_ro; acc && pwrite && map && paddr >= 8'h20 |=> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("read-only write not refused");
  property p_badop; acc && pwrite && paddr == 8'h00 && pwdata[5:0] > 6'h22 |=> pslverr; endproperty
  a_badop: assert property (p_badop) else $error("bad opcode not refused");
  property p_busy_wr; acc && pwrite && left > 3'h1 |=> pslverr; endproperty
  a_busy_wr: assert property (p_busy_wr) else $error("write while busy not refused");
  property p_rd_ok; acc && !pwrite && map |=> !pslverr; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
  property p_busy; pready && !pwrite && paddr == 8'h28 |-> prdata[0] == ($past(left) != 3'h0); endproperty
  a_busy: assert property (p_busy)
    else $error("busy does not match the cycle count");
endmodule
bind aje_exec aje_exec_checker aje_exec_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

/* testbench/aje_apb_master.sv */
// APB master model that issues register transfers to the datapath.
`timescale 1ns/1ps
module aje_apb_master (
  // Clock.
  input  wire logic        pclk,
  // APB request.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  // APB answer.
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Entered just after a rising edge; leaves psel up so transfers may follow back to back.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    penable <= 1'b0;
  endtask
  // Released address and data lines show the inverse of their last value.
  task automatic idle();
    psel <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
endmodule

/* testbench/aje_exec_bench.sv */
// Self-checking bench for the execution datapath over APB.
`timescale 1ns/1ps
`include "aje_regs.svh"
module aje_exec_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #5 pclk = ~pclk;
  aje_exec aje_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aje_apb_master aje_apb_master_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ==========================================
  // Comparison, verdict and timeout.
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      print_verdict();
    end
  end
  // ==========================================
  // Register access, with read data compared to d.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    aje_apb_master_i.xfer(w, a, d, q, e);
    check($sformatf("pslverr %h", a), {31'h0, e}, {31'h0, ee});
    if (!w && !ee) check($sformatf("reg %h", a), q, d);
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    logic        e;
    do aje_apb_master_i.xfer(1'b0, `AJE_OFF_STAT, 32'h0, q, e); while (q[0] === 1'b1);
  endtask
  // Loads operands, runs one operation and compares result and flags.
  task automatic t(input logic [5:0] op, input logic [15:0] w, input logic [7:0] b, input logic [7:0] fi,
                   input logic [15:0] xr, input logic [7:0] xf);
    logic [7:0] k;
    acc(1'b1, `AJE_OFF_OPA, {24'h0, w[7:0]}, 1'b0);
    acc(1'b1, `AJE_OFF_OPB, {24'h0, b}, 1'b0);
    acc(1'b1, `AJE_OFF_WORD, {16'h0, w}, 1'b0);
    acc(1'b1, `AJE_OFF_PTR, {16'h0, w}, 1'b0);
    acc(1'b1, `AJE_OFF_TGT, {16'h0, w}, 1'b0);
    acc(1'b1, `AJE_OFF_PC, 32'h100, 1'b0);
    acc(1'b1, `AJE_OFF_FLAGS, {24'h0, fi}, 1'b0);
    acc(1'b1, `AJE_OFF_CMD, {26'h0, op}, 1'b0);
    wait_idle();
    k = `AJE_OFF_RES;
    if (op == 6'h02 || op == 6'h07) k = `AJE_OFF_WORD;
    if (op > 6'h15) k = `AJE_OFF_PROD;
    if (op > 6'h1b) k = `AJE_OFF_PC;
    acc(1'b0, k, {16'h0, xr}, 1'b0);
    acc(1'b0, `AJE_OFF_FLAGS, {24'h0, xf}, 1'b0);
    acc(1'b0, `AJE_OFF_CMD, {26'h0, op}, 1'b0);
  endtask
  // ==========================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i <= 40; i += 4) acc(1'b0, 8'(i), 32'h0, 1'b0);
    t(6'h00, 16'h0088, 8'h88, 8'h00, 16'h0010, 8'h29);
    t(6'h01, 16'h007f, 8'h00, 8'h01, 16'h0080, 8'h2c);
    t(6'h02, 16'hfffe, 8'h02, 8'h20, 16'h0000, 8'h23);
    t(6'h03, 16'h0010, 8'h01, 8'h00, 16'h000f, 8'h20);
    t(6'h04, 16'h0080, 8'h01, 8'h00, 16'h007f, 8'h28);
    t(6'h05, 16'h0001, 8'h00, 8'h03, 16'h0000, 8'h02);
    t(6'h06, 16'h0000, 8'h00, 8'h01, 16'h00ff, 8'h25);
    t(6'h07, 16'h0000, 8'h01, 8'h00, 16'hffff, 8'h15);
    t(6'h08, 16'h00f0, 8'h8f, 8'h0f, 16'h0080, 8'h05);
    t(6'h09, 16'h000f, 8'hf0, 8'h00, 16'h0000, 8'h02);
    t(6'h0a, 16'h0040, 8'h80, 8'h08, 16'h00c0, 8'h04);
    t(6'h0b, 16'h0000, 8'h00, 8'h04, 16'h0000, 8'h02);
    t(6'h0c, 16'h00aa, 8'hff, 8'h06, 16'h0055, 8'h00);
    t(6'h0d, 16'h0000, 8'h00, 8'h20, 16'h00ff, 8'h25);
    t(6'h0e, 16'h0080, 8'h00, 8'h20, 16'h0080, 8'h0d);
    t(6'h0f, 16'h0001, 8'h80, 8'h00, 16'h0081, 8'h04);
    t(6'h10, 16'h00ff, 8'h0f, 8'h01, 16'h00f0, 8'h05);
    t(6'h11, 16'h007f, 8'h00, 8'h01, 16'h0080, 8'h0d);
    t(6'h12, 16'h0080, 8'h00, 8'h00, 16'h007f, 8'h08);
    t(6'h13, 16'h0000, 8'h00, 8'h0c, 16'h0000, 8'h02);
    t(6'h14, 16'h005a, 8'h00, 8'h0c, 16'h0000, 8'h02);
    t(6'h15, 16'h0012, 8'h00, 8'h2a, 16'h00ff, 8'h2a);
    t(6'h16, 16'h00ff, 8'hff, 8'h3c, 16'hfe01, 8'h3d);
    t(6'h17, 16'h00ff, 8'h02, 8'h3c, 16'hfffe, 8'h3d);
    t(6'h18, 16'h00ff, 8'hff, 8'h3c, 16'hff01, 8'h3d);
    t(6'h19, 16'h00ff, 8'hff, 8'h3c, 16'hfc02, 8'h3d);
    t(6'h1a, 16'h00c0, 8'h40, 8'h3c, 16'he000, 8'h3d);
    t(6'h1b, 16'h00c0, 8'hc0, 8'h3c, 16'ha000, 8'h3d);
    t(6'h1c, 16'hfffe, 8'h00, 8'h3f, 16'h00ff, 8'h3f);
    t(6'h1d, 16'h1234, 8'h00, 8'h3f, 16'h1234, 8'h3f);
    t(6'h1e, 16'h0abc, 8'h00, 8'h3f, 16'h0abc, 8'h3f);
    t(6'h1f, 16'h0010, 8'h00, 8'h3f, 16'h0111, 8'h3f);
    t(6'h22, 16'h0000, 8'h00, 8'h3f, 16'h0101, 8'h3f);
    t(6'h20, 16'h2000, 8'h00, 8'h3f, 16'h2000, 8'h3f);
    t(6'h22, 16'h0000, 8'h00, 8'h3f, 16'h0101, 8'h3f);
    t(6'h21, 16'h3000, 8'h00, 8'h3f, 16'h3000, 8'h3f);
    t(6'h22, 16'h0000, 8'h00, 8'h3f, 16'h0102, 8'h3f);
    acc(1'b0, 8'h2c, 32'h0, 1'b1);
    acc(1'b0, 8'h02, 32'h0, 1'b1);
    acc(1'b1, `AJE_OFF_RES, 32'h0, 1'b1);
    acc(1'b1, `AJE_OFF_CMD, 32'h23, 1'b1);
    acc(1'b1, `AJE_OFF_CMD, 32'h1e, 1'b0);
    acc(1'b1, `AJE_OFF_OPA, 32'h0, 1'b1);
    wait_idle();
    aje_apb_master_i.idle();
    print_verdict();
  end
endmodule
